// File: rtl/ppm_pkg.sv
/*
 * Constants, states and a helper function for the port pin map and
 * external data bus block.
 * Assumes one 50 MHz core clock and an asynchronous active-high reset.
 */
// Functional notes
// - port 0 carries address then data, else open-drain
// - port 0 pull-ups switched by software
// - p1.0 timer3 count, p1.1 timer3 reload control
// - p1.4 to p1.7 are irq 2 to 5
// - port 2 drives high address during access
// - p2.6 and p2.7 request loader reboot
// - p3.0 serial a receive, p3.1 transmit
// - p3.2/3 irq 0/1, p3.4/5 timer1/2 counts
// - p3.6 write strobe, p3.7 read strobe
// - port 4 four bits, p4.0 wait input
// - p4.3 requests loader reboot
// - machine cycle is four clocks
// - with wait off, external data access lasts two to nine machine cycles
// - 1KB on-chip data ram, switchable, 0000h-03ffh
// - after reset all accesses go external
// - addresses above 03ffh always go external
// - wait enabled makes p4.0 input only
package ppm_pkg;
    localparam int PPM_CLK_HZ = 50_000_000;
    localparam int PPM_CLKS_PER_MC = 4;
    localparam logic [1:0] PPM_MC_LAST = 2'h3;
    localparam int PPM_XRAM_BYTES = 1024;
    localparam logic [15:0] PPM_XRAM_TOP = 16'h03ff;
    localparam int PPM_XRAM_AW = 10;
    localparam int PPM_MIN_MC = 2;
    localparam int PPM_MAX_MC = 9;
    localparam logic [3:0] PPM_ACC_BASE_MC = 4'h2;
    // ale stays high for the first half of the address machine cycle
    localparam logic [1:0] PPM_ALE_PHASES = 2'h2;
    // bit positions
    localparam int PPM_P1_T3CNT = 0;
    localparam int PPM_P1_T3CTL = 1;
    localparam int PPM_P1_SBRX = 2;
    localparam int PPM_P1_SBTX = 3;
    localparam int PPM_P1_IRQ2 = 4;
    localparam int PPM_P2_RBA = 6;
    localparam int PPM_P2_RBB = 7;
    localparam int PPM_P3_SARX = 0;
    localparam int PPM_P3_SATX = 1;
    localparam int PPM_P3_IRQ0 = 2;
    localparam int PPM_P3_IRQ1 = 3;
    localparam int PPM_P3_T1CNT = 4;
    localparam int PPM_P3_T2CNT = 5;
    localparam int PPM_P3_WR = 6;
    localparam int PPM_P3_RD = 7;
    localparam int PPM_P4_WAIT = 0;
    localparam int PPM_P4_RB = 3;
    localparam logic [7:0] PPM_P8_RST = 8'hff;
    localparam logic [3:0] PPM_P4_RST = 4'hf;

    typedef enum logic [4:0] {
        PPM_IDLE = 5'b00001,
        PPM_EXT_ADDR = 5'b00010,
        PPM_EXT_STRB = 5'b00100,
        PPM_ONCHIP = 5'b01000,
        PPM_DONE = 5'b10000
    } ppm_state_t;

    function automatic logic ppm_is_onchip(input logic [15:0] addr, input logic en);
        return en && (addr <= PPM_XRAM_TOP);
    endfunction
endpackage

// File: rtl/ppm_xram.sv
/*
 * Single-port on-chip data ram with registered read data.
 * Assumes the caller holds en for one clock per access.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_xram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // clock
    input wire logic mclk,
    // access
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    // no reset on the array so it maps to ram macros
    always_ff @(posedge mclk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// File: rtl/ppm_pin_mux.sv
/*
 * Port pin map with alternate functions, external data bus on ports
 * 0 and 2 with stretched strobes, and routing to the on-chip data ram.
 * Assumes pins are resolved outside: an oe_n low means the pin is driven
 * with the out value, high means released to its pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_mux (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // port latches from the core
    input wire logic [7:0] p0_latch,
    input wire logic [7:0] p1_latch,
    input wire logic [7:0] p2_latch,
    input wire logic [7:0] p3_latch,
    input wire logic [3:0] p4_latch,
    // control levels from the core
    input wire logic p0_pullup_sw,
    input wire logic onchip_xram_enable,
    input wire logic wait_enable,
    input wire logic [2:0] access_stretch,
    // data move request from the core
    input wire logic xreq,
    input wire logic xwrite,
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    output logic xdone,
    output logic [7:0] xrdata,
    output logic mc_tick,
    // alternate outputs from peripherals
    input wire logic serial_a_tx,
    input wire logic serial_b_tx,
    // alternate inputs to peripherals
    output logic timer1_count_in,
    output logic timer2_count_in,
    output logic timer3_count_in,
    output logic timer3_reload_capture_dir_in,
    output logic serial_a_rx,
    output logic serial_b_rx,
    output logic ext_irq_0_in,
    output logic ext_irq_1_in,
    output logic ext_irq_2_in,
    output logic ext_irq_3_in,
    output logic ext_irq_4_in,
    output logic ext_irq_5_in,
    output logic reboot_req,
    output logic [7:0] p0_sync,
    output logic [7:0] p1_sync,
    output logic [7:0] p2_sync,
    output logic [7:0] p3_sync,
    output logic [3:0] p4_sync,
    // pins
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe_n,
    output logic p0_pullup_on,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_n,
    input wire logic [3:0] p4_in,
    output logic [3:0] p4_out,
    output logic [3:0] p4_oe_n,
    output logic ale
);
    import ppm_pkg::*;

    logic [35:0] meta_r;
    logic [35:0] sync_r;
    logic [1:0] ph_r;
    ppm_state_t state_r;
    logic [3:0] mc_cnt_r;
    logic [3:0] mc_len_r;
    logic [15:0] addr_r;
    logic [7:0] wdata_r;
    logic write_r;
    logic onchip_wr_r;
    logic hit;
    logic mem_en;
    logic [7:0] mem_rdata;
    logic bus_on;
    logic wait_hold;
    logic rd_n;
    logic wr_n;

    // pins come from outside the clock domain: two flops before use
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_r <= {PPM_P4_RST, PPM_P8_RST, PPM_P8_RST, PPM_P8_RST, PPM_P8_RST};
            sync_r <= {PPM_P4_RST, PPM_P8_RST, PPM_P8_RST, PPM_P8_RST, PPM_P8_RST};
        end else begin
            meta_r <= {p4_in, p3_in, p2_in, p1_in, p0_in};
            sync_r <= meta_r;
        end
    end
    assign p0_sync = sync_r[7:0];
    assign p1_sync = sync_r[15:8];
    assign p2_sync = sync_r[23:16];
    assign p3_sync = sync_r[31:24];
    assign p4_sync = sync_r[35:32];

    // alternate inputs
    assign timer3_count_in = p1_sync[PPM_P1_T3CNT];
    assign timer3_reload_capture_dir_in = p1_sync[PPM_P1_T3CTL];
    assign serial_b_rx = p1_sync[PPM_P1_SBRX];
    assign ext_irq_2_in = p1_sync[PPM_P1_IRQ2];
    assign ext_irq_3_in = p1_sync[PPM_P1_IRQ2+1];
    assign ext_irq_4_in = p1_sync[PPM_P1_IRQ2+2];
    assign ext_irq_5_in = p1_sync[PPM_P1_IRQ2+3];
    assign serial_a_rx = p3_sync[PPM_P3_SARX];
    assign ext_irq_0_in = p3_sync[PPM_P3_IRQ0];
    assign ext_irq_1_in = p3_sync[PPM_P3_IRQ1];
    assign timer1_count_in = p3_sync[PPM_P3_T1CNT];
    assign timer2_count_in = p3_sync[PPM_P3_T2CNT];

    // reboot is active low; synced p2 pins are masked by bus_on, which falls two clocks before they stop carrying address
    assign reboot_req = (!bus_on && !p2_sync[PPM_P2_RBA] && !p2_sync[PPM_P2_RBB])
        || !p4_sync[PPM_P4_RB];

    // wait is active low, read only while enabled
    assign wait_hold = wait_enable && !p4_sync[PPM_P4_WAIT];

    // machine cycle phase counter
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ph_r <= 2'h0;
        end else begin
            ph_r <= ph_r + 2'h1;
        end
    end
    assign mc_tick = (ph_r == PPM_MC_LAST);

    assign hit = ppm_is_onchip(xaddr, onchip_xram_enable);
    assign mem_en = (state_r == PPM_IDLE) && xreq && hit;

    // access sequencer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= PPM_IDLE;
            mc_cnt_r <= 4'h0;
            mc_len_r <= 4'h0;
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
            write_r <= 1'b0;
        end else begin
            case (state_r)
                PPM_IDLE: begin
                    if (mem_en) begin
                        state_r <= PPM_ONCHIP;
                    end else if (xreq && !hit && mc_tick) begin
                        state_r <= PPM_EXT_ADDR;
                        addr_r <= xaddr;
                        wdata_r <= xwdata;
                        write_r <= xwrite;
                        mc_cnt_r <= 4'h1;
                        mc_len_r <= PPM_ACC_BASE_MC + {1'b0, access_stretch};
                    end
                end
                PPM_EXT_ADDR: begin
                    if (mc_tick) begin
                        state_r <= PPM_EXT_STRB;
                        mc_cnt_r <= mc_cnt_r + 4'h1;
                    end
                end
                PPM_EXT_STRB: begin
                    if (mc_tick) begin
                        if (mc_cnt_r >= mc_len_r && !wait_hold) begin
                            state_r <= PPM_DONE;
                        end else begin
                            mc_cnt_r <= mc_cnt_r + 4'h1;
                        end
                    end
                end
                PPM_ONCHIP: begin
                    state_r <= PPM_DONE;
                end
                PPM_DONE: begin
                    state_r <= PPM_IDLE;
                end
                default: begin
                    state_r <= PPM_IDLE;
                end
            endcase
        end
    end

    // read data capture
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xrdata <= 8'h00;
        end else if (state_r == PPM_ONCHIP && !onchip_wr_r) begin
            xrdata <= mem_rdata;
        end else if (state_r == PPM_EXT_STRB && mc_tick && !write_r) begin
            xrdata <= p0_sync;
        end
    end
    assign xdone = (state_r == PPM_DONE);

    ppm_xram #(
        .DEPTH(PPM_XRAM_BYTES),
        .AW(PPM_XRAM_AW)
    ) u_xram (
        .mclk(mclk),
        .en(mem_en),
        .we(xwrite),
        .addr(xaddr[PPM_XRAM_AW-1:0]),
        .wdata(xwdata),
        .rdata(mem_rdata)
    );

    // the onchip path needs write_r too; it is only loaded for the bus path,
    // so onchip reads are qualified by the write flag captured here
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            onchip_wr_r <= 1'b0;
        end else if (mem_en) begin
            onchip_wr_r <= xwrite;
        end
    end

    assign bus_on = (state_r == PPM_EXT_ADDR) || (state_r == PPM_EXT_STRB);
    assign ale = (state_r == PPM_EXT_ADDR) && (ph_r < PPM_ALE_PHASES);
    assign rd_n = !(state_r == PPM_EXT_STRB && !write_r);
    assign wr_n = !(state_r == PPM_EXT_STRB && write_r);

    // port 0: strong drive of address and write data, released for read data, open-drain otherwise
    always_comb begin
        if (state_r == PPM_EXT_ADDR) begin
            p0_out = addr_r[7:0];
            p0_oe_n = 8'h00;
        end else if (state_r == PPM_EXT_STRB) begin
            p0_out = wdata_r;
            p0_oe_n = write_r ? 8'h00 : 8'hff;
        end else begin
            p0_out = 8'h00;
            p0_oe_n = p0_latch;
        end
    end
    // pull-ups are of no use while the bus drives hard
    assign p0_pullup_on = p0_pullup_sw && !bus_on;

    // port 2: high address during access, quasi-bidirectional otherwise
    assign p2_out = bus_on ? addr_r[15:8] : p2_latch;
    assign p2_oe_n = bus_on ? 8'h00 : p2_latch;

    // ports 1 and 3: latch combined with the alternate output
    always_comb begin
        p1_out = p1_latch;
        p1_out[PPM_P1_SBTX] = p1_latch[PPM_P1_SBTX] & serial_b_tx;
        p3_out = p3_latch;
        p3_out[PPM_P3_SATX] = p3_latch[PPM_P3_SATX] & serial_a_tx;
        p3_out[PPM_P3_WR] = p3_latch[PPM_P3_WR] & wr_n;
        p3_out[PPM_P3_RD] = p3_latch[PPM_P3_RD] & rd_n;
    end
    // a one is released to the pull-up so the pin can be read as input
    assign p1_oe_n = p1_out;
    assign p3_oe_n = p3_out;

    // port 4
    always_comb begin
        p4_out = p4_latch;
        p4_oe_n = p4_latch;
        if (wait_enable) begin
            p4_out[PPM_P4_WAIT] = 1'b1;
            p4_oe_n[PPM_P4_WAIT] = 1'b1;
        end
    end

    // assertion helper: clocks spent in the current external access
    logic [6:0] acc_clk_r;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc_clk_r <= 7'h00;
        end else if (bus_on) begin
            acc_clk_r <= acc_clk_r + 7'h01;
        end else begin
            acc_clk_r <= 7'h00;
        end
    end

    a_tick_period: assert property (@(posedge mclk) disable iff (reset)
        mc_tick |=> !mc_tick [*3] ##1 mc_tick)
        else $error("machine cycle is not four clocks");
    a_acc_length: assert property (@(posedge mclk) disable iff (reset)
        $fell(bus_on) && !$past(wait_enable) |->
        $past(acc_clk_r) == 7'(PPM_CLKS_PER_MC) * 7'($past(mc_len_r)) - 7'h01)
        else $error("external access length wrong");
    a_acc_bound: assert property (@(posedge mclk) disable iff (reset)
        bus_on && !wait_enable |-> acc_clk_r < 7'(PPM_CLKS_PER_MC * PPM_MAX_MC))
        else $error("external access over nine machine cycles");
    a_onchip_route: assert property (@(posedge mclk) disable iff (reset)
        state_r == PPM_IDLE && xreq && onchip_xram_enable && xaddr <= PPM_XRAM_TOP
        |=> state_r == PPM_ONCHIP ##1 xdone)
        else $error("on-chip ram access not routed");
    a_off_external: assert property (@(posedge mclk) disable iff (reset)
        state_r == PPM_IDLE && xreq && !onchip_xram_enable && mc_tick
        |=> state_r == PPM_EXT_ADDR)
        else $error("disabled ram access not external");
    a_high_external: assert property (@(posedge mclk) disable iff (reset)
        state_r == PPM_IDLE && xreq && xaddr > PPM_XRAM_TOP |-> !mem_en)
        else $error("high address reached on-chip ram");
    a_p2_address: assert property (@(posedge mclk) disable iff (reset)
        bus_on |-> p2_out == addr_r[15:8] && p2_oe_n == 8'h00)
        else $error("port 2 not carrying high address");
    a_p0_addr: assert property (@(posedge mclk) disable iff (reset)
        $rose(ale) |-> p0_out == addr_r[7:0] && p0_oe_n == 8'h00)
        else $error("port 0 not carrying low address");
    a_read_strobe: assert property (@(posedge mclk) disable iff (reset)
        $rose(bus_on) && !write_r |-> ##4 !p3_out[PPM_P3_RD] [*4])
        else $error("read strobe missing");
    a_wait_input: assert property (@(posedge mclk) disable iff (reset)
        wait_enable |-> p4_oe_n[PPM_P4_WAIT])
        else $error("wait pin driven while enabled");

    c_ext_read: cover property (@(posedge mclk) disable iff (reset)
        xdone && !write_r && $past(state_r) == PPM_EXT_STRB);
    c_ext_write: cover property (@(posedge mclk) disable iff (reset)
        !wr_n ##1 wr_n);
    c_onchip: cover property (@(posedge mclk) disable iff (reset)
        state_r == PPM_ONCHIP);
    c_wait: cover property (@(posedge mclk) disable iff (reset)
        state_r == PPM_EXT_STRB && mc_tick && wait_hold);
endmodule
`default_nettype wire

// File: testbench/ppm_xmem_model.sv
/*
 * External data memory model for the port pin map bench.
 * Assumes the bench resolves the pins and feeds back their levels.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_xmem_model (
    // clock
    input wire logic mclk,
    // bus pins
    input wire logic ale,
    input wire logic [7:0] ad_pin,
    input wire logic [7:0] a_hi_pin,
    input wire logic wr_n_pin,
    input wire logic rd_n_pin,
    // slow part emulation and drive
    input wire logic [3:0] wait_mc,
    output logic wait_n,
    output logic mem_drive,
    output logic [7:0] mem_data
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_r;
    logic [7:0] last_r = 8'h00;
    logic [15:0] wcnt_r = 16'h0000;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // once released the bus toggles, so stale data never looks valid
    assign mem_drive = !rd_n_pin;
    assign mem_data = mem_drive ? mem[addr_r] : ~last_r;
    assign wait_n = !((!rd_n_pin || !wr_n_pin) && (wcnt_r < {10'h000, wait_mc, 2'h0}));
    always @(posedge mclk) begin
        last_r <= mem_data;
        if (ale) begin
            addr_r <= {a_hi_pin, ad_pin};
        end
        if (!wr_n_pin) begin
            mem[addr_r] <= ad_pin;
        end
        if (rd_n_pin && wr_n_pin) begin
            wcnt_r <= 16'h0000;
        end else if (wcnt_r != 16'hffff) begin
            wcnt_r <= wcnt_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb.sv
/*
 * Self-checking bench for the port pin map and external data bus.
 * Assumes the memory model on ports 0, 2 and 3 and pins resolved here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ppm_pkg::*;
    typedef struct {logic rd; logic [7:0] exp;} ppm_note_t;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] p0_latch = 8'hff, p1_latch = 8'hff, p2_latch = 8'hff, p3_latch = 8'hff;
    logic [3:0] p4_latch = 4'hf, p4_ext = 4'hf, wait_mc = 4'h0;
    logic [7:0] p1_ext = 8'hff, p2_ext = 8'hff, p3_ext = 8'hff;
    logic p0_pullup_sw = 1'b0, onchip_xram_enable = 1'b0, wait_enable = 1'b0;
    logic [2:0] access_stretch = 3'h0;
    logic xreq = 1'b0, xwrite = 1'b0, serial_a_tx = 1'b1, serial_b_tx = 1'b1;
    logic [15:0] xaddr = 16'h0000, cur_addr = 16'h0000, a;
    logic [7:0] xwdata = 8'h00, d;
    wire logic xdone, mc_tick, ale, p0_pullup_on, wait_n, mem_drive, reboot_req;
    wire logic [7:0] xrdata, mem_data, p0_out, p0_oe_n, p1_out, p1_oe_n, p2_out, p2_oe_n, p3_out, p3_oe_n;
    wire logic [3:0] p4_out, p4_oe_n, p4_sync;
    wire logic [7:0] p1_sync, p2_sync, p3_sync;
    wire logic t1c, t2c, t3c, t3x, sarx, sbrx, i0, i1, i2, i3, i4, i5;
    wire logic [7:0] p0_pin, p1_pin, p2_pin, p3_pin;
    wire logic [3:0] p4_pin;
    int n_mismatch = 0, checked = 0, n_ale = 0, n_rd = 0, n_wr = 0, tick_gap = 0;
    logic tick_seen = 1'b0;
    ppm_note_t notes[$];
    ppm_note_t note;

    always #10 mclk = ~mclk;
    // the pull-up only wins where nobody drives port 0
    assign p0_pin = (~p0_oe_n & p0_out) | (p0_oe_n & ((mem_drive || !p0_pullup_on) ? mem_data : 8'hff));
    assign p1_pin = (~p1_oe_n & p1_out) | (p1_oe_n & p1_ext);
    assign p2_pin = (~p2_oe_n & p2_out) | (p2_oe_n & p2_ext);
    assign p3_pin = (~p3_oe_n & p3_out) | (p3_oe_n & p3_ext);
    assign p4_pin = (~p4_oe_n & p4_out) | (p4_oe_n & {p4_ext[3:1], p4_ext[0] & wait_n});

    ppm_pin_mux dut (.mclk(mclk), .reset(reset), .p0_latch(p0_latch), .p1_latch(p1_latch),
        .p2_latch(p2_latch), .p3_latch(p3_latch), .p4_latch(p4_latch), .p0_pullup_sw(p0_pullup_sw),
        .onchip_xram_enable(onchip_xram_enable), .wait_enable(wait_enable), .access_stretch(access_stretch),
        .xreq(xreq), .xwrite(xwrite), .xaddr(xaddr), .xwdata(xwdata), .xdone(xdone), .xrdata(xrdata),
        .mc_tick(mc_tick), .serial_a_tx(serial_a_tx), .serial_b_tx(serial_b_tx), .timer1_count_in(t1c),
        .timer2_count_in(t2c), .timer3_count_in(t3c), .timer3_reload_capture_dir_in(t3x),
        .serial_a_rx(sarx), .serial_b_rx(sbrx), .ext_irq_0_in(i0), .ext_irq_1_in(i1), .ext_irq_2_in(i2),
        .ext_irq_3_in(i3), .ext_irq_4_in(i4), .ext_irq_5_in(i5), .reboot_req(reboot_req), .p0_sync(),
        .p1_sync(p1_sync), .p2_sync(p2_sync), .p3_sync(p3_sync), .p4_sync(p4_sync), .p0_in(p0_pin),
        .p0_out(p0_out),
        .p0_oe_n(p0_oe_n), .p0_pullup_on(p0_pullup_on), .p1_in(p1_pin), .p1_out(p1_out), .p1_oe_n(p1_oe_n),
        .p2_in(p2_pin), .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p3_in(p3_pin), .p3_out(p3_out),
        .p3_oe_n(p3_oe_n), .p4_in(p4_pin), .p4_out(p4_out), .p4_oe_n(p4_oe_n), .ale(ale));

    ppm_xmem_model u_mem (.mclk(mclk), .ale(ale), .ad_pin(p0_pin), .a_hi_pin(p2_pin), .wr_n_pin(p3_pin[6]),
        .rd_n_pin(p3_pin[7]), .wait_mc(wait_mc), .wait_n(wait_n), .mem_drive(mem_drive), .mem_data(mem_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one data move; the latency window allows up to three clocks waiting for the machine-cycle tick
    task automatic xfer(input logic wr, input logic [15:0] ad, input logic [7:0] wd, input logic [7:0] exp,
        input int s, input logic onchip, input int wmc);
        int i;
        int lo;
        int hi;
        lo = onchip ? 3 : 4 * (s + 2) + 2 + (wmc > 0 ? 4 : 0);
        hi = onchip ? 3 : 4 * (s + 2) + 5 + (wmc > 0 ? 4 * (wmc + 1) : 0);
        notes.push_back('{!wr, exp});
        cur_addr = ad;
        n_ale = 0;
        n_rd = 0;
        n_wr = 0;
        @(posedge mclk);
        xreq <= 1'b1;
        xwrite <= wr;
        xaddr <= ad;
        xwdata <= wd;
        i = 0;
        // xdone is looked at mid-cycle, where it has settled
        do begin
            @(negedge mclk);
            i++;
        end while (xdone !== 1'b1 && i < 300);
        @(posedge mclk);
        xreq <= 1'b0;
        check(16'(i >= lo && i <= hi), 16'h0001);
        if (i >= 300) begin
            finish_test();
        end
        check(16'(n_ale), onchip ? 16'h0000 : 16'h0002);
        if (onchip) begin
            check(16'(n_rd + n_wr), 16'h0000);
        end else if (wmc == 0) begin
            check(16'(wr ? n_wr : n_rd), 16'(4 * (s + 1)));
        end
        check(16'(wr ? n_rd : n_wr), 16'h0000);
    endtask

    always @(negedge mclk) begin
        if (!reset) begin
            if (ale === 1'b1) begin
                n_ale++;
                check({p2_out, p0_out}, cur_addr);
                check({p2_oe_n, p0_oe_n}, 16'h0000);
            end
            n_rd += (p3_pin[7] === 1'b0);
            n_wr += (p3_pin[6] === 1'b0);
            if (mc_tick === 1'b1) begin
                if (tick_seen) check(16'(tick_gap), 16'h0004);
                tick_seen = 1'b1;
                tick_gap = 0;
            end
            tick_gap++;
            if (xdone === 1'b1) begin
                if (notes.size() == 0) begin
                    check(16'h0000, 16'h0001);
                end else begin
                    note = notes.pop_front();
                    if (note.rd) check(xrdata, note.exp);
                end
            end
        end
    end

    initial begin
        void'($urandom(68));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (12) begin
            @(posedge mclk);
            {p1_ext, p2_ext, p4_ext} <= 20'($urandom);
            p3_ext <= 8'($urandom) | 8'hc0;
            {p0_latch, p1_latch, p2_latch, p4_latch} <= 28'($urandom);
            p3_latch <= 8'($urandom) | 8'hc0;
            {serial_a_tx, serial_b_tx, p0_pullup_sw, wait_enable} <= 4'($urandom);
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            check(p1_out, p1_latch & {4'hf, serial_b_tx, 3'h7});
            check(p1_oe_n, p1_latch & {4'hf, serial_b_tx, 3'h7});
            check(p3_out, p3_latch & {6'h3f, serial_a_tx, 1'b1});
            check(p3_oe_n, p3_latch & {6'h3f, serial_a_tx, 1'b1});
            check({p0_oe_n, p0_out}, {p0_latch, 8'h00});
            check(p0_pullup_on, p0_pullup_sw);
            check(p2_out, p2_latch);
            check({p2_sync, p1_sync}, {p2_pin, p1_pin});
            check(p3_sync, p3_pin);
            check({t3x, t3c}, p1_pin[1:0]);
            check(sbrx, p1_pin[2]);
            check({i5, i4, i3, i2}, p1_pin[7:4]);
            check(sarx, p3_pin[0]);
            check({t2c, t1c, i1, i0}, p3_pin[5:2]);
            check(reboot_req, (p2_pin[7:6] == 2'b00) || !p4_pin[3]);
            check({p4_sync, p4_out}, {p4_pin, p4_latch[3:1], p4_latch[0] | wait_enable});
            if (wait_enable) check(p4_oe_n[0], 1'b1);
        end
        @(posedge mclk);
        // wait input off so the plain access length is checked exactly
        wait_enable <= 1'b0;
        p4_ext <= 4'hf;
        p3_latch <= 8'hff;
        p3_ext <= 8'hff;
        for (int s = 0; s < 8; s++) begin
            access_stretch <= 3'(s);
            // bit 11 keeps random addresses clear of the fixed ones used below
            a = 16'($urandom) | 16'h0800;
            d = 8'($urandom);
            xfer(1'b1, a, d, 8'h00, s, 1'b0, 0);
            check(u_mem.mem[a], d);
            xfer(1'b0, a, 8'h00, d, s, 1'b0, 0);
        end
        access_stretch <= 3'h1;
        xfer(1'b1, 16'h0010, 8'h3c, 8'h00, 1, 1'b0, 0);
        onchip_xram_enable <= 1'b1;
        xfer(1'b1, 16'h0010, 8'hc3, 8'h00, 1, 1'b1, 0);
        xfer(1'b1, 16'h03ff, 8'h96, 8'h00, 1, 1'b1, 0);
        xfer(1'b0, 16'h0010, 8'h00, 8'hc3, 1, 1'b1, 0);
        xfer(1'b0, 16'h03ff, 8'h00, 8'h96, 1, 1'b1, 0);
        check({u_mem.mem[16'h0010], u_mem.mem[16'h03ff]}, {8'h3c, 8'hff ^ 8'h5a});
        xfer(1'b1, 16'h0400, 8'h69, 8'h00, 1, 1'b0, 0);
        check(u_mem.mem[16'h0400], 8'h69);
        onchip_xram_enable <= 1'b0;
        xfer(1'b0, 16'h0010, 8'h00, 8'h3c, 1, 1'b0, 0);
        access_stretch <= 3'h0;
        wait_enable <= 1'b1;
        wait_mc <= 4'h2;
        xfer(1'b0, 16'h0400, 8'h00, 8'h69, 0, 1'b0, 2);
        finish_test();
    end
endmodule
`default_nettype wire
